// >>> hdl/lcd_instruction_decoder.sv
// instruction decoder: host port, ram pointer, busy timer, icon row, contrast
`timescale 1ns/1ps
module lcd_instruction_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host pins; inputs asynchronous to clk, outputs driven from clk registers
    input wire logic selectLineHigh,
    input wire logic selectLineLow,
    input wire logic readNotWrite,
    input wire logic strobe,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    // scan direction pin, asynchronous
    input wire logic commonScanReverse,
    // settings from the entry mode and function set logic
    input wire logic entryIncrement,
    input wire logic twoLineMode,
    input wire logic largeFont,
    // toward drive and refresh logic
    output logic busyIndicator,
    output logic iconRowLineSelect,
    output logic [4:0] iconCommon,
    output logic [4:0] lcdDriveVoltage
);
    // busy length bounds in clk cycles, used by checks only
    localparam int BUSY_MAX = lcd_decoder_pkg::EXEC_TICKS * lcd_decoder_pkg::OSC_DIV;
    localparam int BUSY_MIN = (lcd_decoder_pkg::EXEC_TICKS - 1) * lcd_decoder_pkg::OSC_DIV;

    // whole module state
    typedef struct packed {
        logic [3:0] ctlMeta; // first stage: strobe, high, low, read
        logic [3:0] ctlSync; // second stage
        logic [7:0] dataMeta;
        logic [7:0] dataSync;
        logic scanRevMeta; // scan reverse pin, first stage
        logic scanRevSync; // scan reverse pin, second stage
        logic strobeLast; // edge detect on synced strobe
        logic [6:0] ptr; // shared address pointer
        lcd_decoder_pkg::target_t target; // ram that data goes to
        lcd_decoder_pkg::phase_t phase; // prefetch sequence
        logic lineSel; // icon row line select
        logic [4:0] contrastLevel; // contrast register, feeds the drive voltage
        logic [7:0] readBuf; // prefetched byte
        logic [7:0] dataOut; // byte on the bus during reads
        logic [4:0] iconCommon; // common pin of the icon row
        logic [5:0] oscDiv; // oscillator tick divider
        logic [3:0] busyTicks; // remaining oscillator ticks
        logic [9:0] busyRun; // cycles spent busy, checks only
    } state_t;

    state_t st;
    state_t next_st;

    // synced host view
    logic sHi;
    logic sLo;
    logic sRw;
    logic [7:0] din;
    logic take; // rising edge of synced strobe
    logic busy;
    logic acc; // instruction taken and not refused
    logic oscTick;
    // decoded instructions
    logic isStatus;
    logic isTextAddr;
    logic isGlyphAddr;
    logic isIconAddr;
    logic isDataWr;
    logic isDataRd;
    logic isLineSel;
    logic isContrastWr;
    logic isContrastRd;
    logic [6:0] step;
    logic [4:0] comCount;
    logic [7:0] rdByte;

    // ram ports
    ram_port_if #(.AW(lcd_decoder_pkg::TEXT_AW)) textPort ();
    ram_port_if #(.AW(lcd_decoder_pkg::GLYPH_AW)) glyphPort ();
    ram_port_if #(.AW(lcd_decoder_pkg::ICON_AW)) iconPort ();

    // only the second stage is ever looked at
    assign sHi = st.ctlSync[2];
    assign sLo = st.ctlSync[1];
    assign sRw = st.ctlSync[0];
    assign din = st.dataSync;
    assign take = st.ctlSync[3] & ~st.strobeLast;
    assign oscTick = (st.oscDiv == lcd_decoder_pkg::OSC_LAST);
    assign busy = (st.busyTicks != 4'h0) || (st.phase != lcd_decoder_pkg::PH_IDLE);
    assign acc = take & (~busy | isStatus);

    // instruction decode
    assign isStatus = sHi & ~sLo & sRw;
    assign isTextAddr = sHi & ~sLo & ~sRw & din[lcd_decoder_pkg::TEXT_ADDR_BIT];
    assign isGlyphAddr = sHi & ~sLo & ~sRw & (din[7:6] == lcd_decoder_pkg::GLYPH_ADDR_TAG);
    assign isIconAddr = ~sHi & ~sLo & ~sRw & (din[7:5] == lcd_decoder_pkg::ICON_ADDR_TAG);
    assign isDataWr = sHi & sLo & ~sRw;
    assign isDataRd = sHi & sLo & sRw;
    assign isLineSel = ~sHi & ~sLo & ~sRw & (din[7:1] == lcd_decoder_pkg::LINE_SEL_TAG);
    assign isContrastWr = ~sHi & ~sLo & ~sRw & (din[7:5] == lcd_decoder_pkg::CONTRAST_WR_TAG);
    assign isContrastRd = ~sHi & ~sLo & sRw;

    assign step = entryIncrement ? lcd_decoder_pkg::STEP_UP : lcd_decoder_pkg::STEP_DOWN;
    // line count and font pick the duty
    assign comCount = twoLineMode ? lcd_decoder_pkg::COMS_TWO :
        (largeFont ? lcd_decoder_pkg::COMS_ONE_LARGE : lcd_decoder_pkg::COMS_ONE_SMALL);

    // byte from whichever ram is targeted
    assign rdByte = (st.target == lcd_decoder_pkg::TGT_GLYPH) ? glyphPort.rdData :
        (st.target == lcd_decoder_pkg::TGT_ICON) ? iconPort.rdData : textPort.rdData;

    // store into the targeted ram at the pointer
    assign textPort.wrEn = acc & isDataWr & (st.target == lcd_decoder_pkg::TGT_TEXT);
    assign glyphPort.wrEn = acc & isDataWr & (st.target == lcd_decoder_pkg::TGT_GLYPH);
    assign iconPort.wrEn = acc & isDataWr & (st.target == lcd_decoder_pkg::TGT_ICON);
    // pointer always addresses the ram, so prefetch needs no extra mux
    assign textPort.addr = st.ptr;
    assign glyphPort.addr = st.ptr[5:0];
    assign iconPort.addr = st.ptr[4:0];
    assign textPort.wrData = din;
    assign glyphPort.wrData = din;
    assign iconPort.wrData = din;

    // next state
    always_comb begin
        next_st = st;
        // two stage synchronisers
        next_st.ctlMeta = {strobe, selectLineHigh, selectLineLow, readNotWrite};
        next_st.ctlSync = st.ctlMeta;
        next_st.dataMeta = dataIn;
        next_st.dataSync = st.dataMeta;
        next_st.scanRevMeta = commonScanReverse;
        next_st.scanRevSync = st.scanRevMeta;
        next_st.strobeLast = st.ctlSync[3];
        // free running oscillator ticks pace internal work
        if (oscTick) begin
            next_st.oscDiv = 6'h00;
        end else begin
            next_st.oscDiv = st.oscDiv + 6'h01;
        end
        // busy counts down one per oscillator tick
        if (oscTick && (st.busyTicks != 4'h0)) begin
            next_st.busyTicks = st.busyTicks - 4'h1;
        end
        // check helper: length of the current busy stretch
        next_st.busyRun = busy ? (st.busyRun + 10'h001) : 10'h000;
        // icon row: first common when select differs from reverse
        next_st.iconCommon = (st.lineSel ^ st.scanRevSync) ?
            lcd_decoder_pkg::COM_FIRST : comCount;
        // prefetch: address settles, then the ram byte is caught
        case (st.phase)
            lcd_decoder_pkg::PH_IDLE: begin
                next_st.phase = lcd_decoder_pkg::PH_IDLE;
            end
            lcd_decoder_pkg::PH_FETCH: begin
                next_st.phase = lcd_decoder_pkg::PH_CATCH;
            end
            lcd_decoder_pkg::PH_CATCH: begin
                next_st.readBuf = rdByte;
                next_st.phase = lcd_decoder_pkg::PH_IDLE;
            end
            default: begin
                next_st.phase = lcd_decoder_pkg::PH_IDLE;
            end
        endcase
        if (acc) begin
            // every taken instruction but the status read is timed
            if (!isStatus) begin
                next_st.busyTicks = lcd_decoder_pkg::EXEC_LOAD;
            end
            if (isStatus) begin
                // busy on bit 7, pointer below, no wait
                // pointer is already stepped while busy
                next_st.dataOut = {busy, st.ptr};
            end else if (isTextAddr) begin
                // target sticks until the next address setting
                next_st.ptr = din[6:0];
                next_st.target = lcd_decoder_pkg::TGT_TEXT;
                next_st.phase = lcd_decoder_pkg::PH_FETCH;
            end else if (isGlyphAddr) begin
                next_st.ptr = {1'b0, din[5:0]};
                next_st.target = lcd_decoder_pkg::TGT_GLYPH;
                next_st.phase = lcd_decoder_pkg::PH_FETCH;
            end else if (isIconAddr) begin
                next_st.ptr = {2'h0, din[4:0]};
                next_st.target = lcd_decoder_pkg::TGT_ICON;
                next_st.phase = lcd_decoder_pkg::PH_FETCH;
            end else if (isDataWr) begin
                // step after write, ram stores at the old pointer
                next_st.ptr = st.ptr + step;
            end else if (isDataRd) begin
                next_st.dataOut = st.readBuf;
                next_st.ptr = st.ptr + step;
                next_st.phase = lcd_decoder_pkg::PH_FETCH;
            end else if (isLineSel) begin
                next_st.lineSel = din[0];
            end else if (isContrastWr) begin
                next_st.contrastLevel = din[4:0];
            end else if (isContrastRd) begin
                // contrast on low bits, zeros above
                next_st.dataOut = {lcd_decoder_pkg::CONTRAST_PAD, st.contrastLevel};
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.ptr <= lcd_decoder_pkg::PTR_RESET;
            st.contrastLevel <= lcd_decoder_pkg::CONTRAST_RESET;
            st.lineSel <= lcd_decoder_pkg::LINE_SEL_RESET;
            st.iconCommon <= lcd_decoder_pkg::COMS_ONE_SMALL;
        end else begin
            st <= next_st;
        end
    end

    // rams
    byte_ram #(.AW(lcd_decoder_pkg::TEXT_AW)) textRam (.clk(clk), .port(textPort.store));
    byte_ram #(.AW(lcd_decoder_pkg::GLYPH_AW)) glyphRam (.clk(clk), .port(glyphPort.store));
    byte_ram #(.AW(lcd_decoder_pkg::ICON_AW)) iconRam (.clk(clk), .port(iconPort.store));

    // outputs; bus drive waits one cycle so dataOut is already loaded
    assign dataOut = st.dataOut;
    assign dataOe = st.ctlSync[3] & st.strobeLast & sRw;
    assign busyIndicator = busy;
    assign iconRowLineSelect = st.lineSel;
    assign iconCommon = st.iconCommon;
    // drive code is the contrast register itself
    assign lcdDriveVoltage = st.contrastLevel;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_text_addr_load: assert property (
        acc && isTextAddr |=> st.ptr == $past(din[6:0]) && st.target == lcd_decoder_pkg::TGT_TEXT)
        else $error("text address not loaded");
    a_target_held: assert property (
        !(acc && (isTextAddr || isGlyphAddr || isIconAddr)) |=> st.target == $past(st.target))
        else $error("ram target changed without address setting");
    a_busy_upper: assert property (
        st.busyRun <= 10'(BUSY_MAX))
        else $error("busy lasted too long");
    a_busy_lower: assert property (
        $fell(busy) |-> st.busyRun >= 10'(BUSY_MIN))
        else $error("busy ended too early");
    a_write_step: assert property (
        acc && isDataWr |=> st.ptr == 7'($past(st.ptr) + $past(step)) && st.busyTicks != 4'h0)
        else $error("pointer not stepped after write");
    a_read_return: assert property (
        acc && isDataRd |=> st.dataOut == $past(st.readBuf) ##2 st.phase == lcd_decoder_pkg::PH_IDLE)
        else $error("data read or refill wrong");
    a_status_read: assert property (
        take && isStatus |=> st.dataOut == {$past(busy), $past(st.ptr)})
        else $error("status byte wrong");
    a_refuse_busy: assert property (
        take && busy && !isStatus |=> st.ptr == $past(st.ptr) &&
            st.contrastLevel == $past(st.contrastLevel))
        else $error("instruction taken while busy");
    a_contrast_drive: assert property (
        acc && isContrastWr |=> lcdDriveVoltage == $past(din[4:0]))
        else $error("drive code not following contrast write");
    a_contrast_read: assert property (
        acc && isContrastRd |=> st.dataOut[7:5] == 3'h0 &&
            st.dataOut[4:0] == $past(st.contrastLevel))
        else $error("contrast read wrong");
    a_icon_common: assert property (
        acc && isLineSel && din[0] && !st.scanRevSync && $stable(st.scanRevSync)[*1]
        |=> ##1 (st.scanRevSync || iconCommon == lcd_decoder_pkg::COM_FIRST))
        else $error("icon row common wrong");
endmodule

// >>> inc/lcd_decoder_pkg.sv
// constants and types shared by the lcd instruction decoder and its rams
package lcd_decoder_pkg;
    // clock and internal oscillator
    localparam int CLK_PERIOD_NS = 100;
    localparam int CLK_KHZ = 1000000 / CLK_PERIOD_NS;
    localparam int OSC_KHZ = 270;
    localparam int OSC_DIV = (CLK_KHZ * 1000) / (OSC_KHZ * 1000);
    localparam logic [5:0] OSC_LAST = 6'(OSC_DIV - 1);
    // execution time in oscillator ticks, rounded up
    localparam int EXEC_TIME_NS = 37000;
    localparam int EXEC_TICKS = (EXEC_TIME_NS * OSC_KHZ + 999999) / 1000000;
    localparam logic [3:0] EXEC_LOAD = 4'(EXEC_TICKS);
    // widths
    localparam int DATA_W = 8;
    localparam int PTR_W = 7;
    localparam int TEXT_AW = 7;
    localparam int GLYPH_AW = 6;
    localparam int ICON_AW = 5;
    localparam int CONTRAST_W = 5;
    // instruction field codes
    localparam int TEXT_ADDR_BIT = 7;
    localparam logic [1:0] GLYPH_ADDR_TAG = 2'h1;
    localparam logic [6:0] LINE_SEL_TAG = 7'h01;
    localparam logic [2:0] CONTRAST_WR_TAG = 3'h1;
    localparam logic [2:0] ICON_ADDR_TAG = 3'h3;
    localparam logic [2:0] CONTRAST_PAD = 3'h0;
    // reset values
    localparam logic [6:0] PTR_RESET = 7'h00;
    localparam logic [4:0] CONTRAST_RESET = 5'h00;
    localparam logic LINE_SEL_RESET = 1'b0;
    // pointer steps, modulo the pointer width
    localparam logic [6:0] STEP_UP = 7'h01;
    localparam logic [6:0] STEP_DOWN = 7'h7F;
    // common output counts per duty
    localparam logic [4:0] COMS_ONE_SMALL = 5'h09;
    localparam logic [4:0] COMS_ONE_LARGE = 5'h0C;
    localparam logic [4:0] COMS_TWO = 5'h11;
    localparam logic [4:0] COM_FIRST = 5'h01;
    // ram targets
    typedef enum logic [1:0] {
        TGT_TEXT = 2'h0,
        TGT_GLYPH = 2'h1,
        TGT_ICON = 2'h2
    } target_t;
    // prefetch sequence, gray from idle to catch, two bits change on the return to idle
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_FETCH = 2'h1,
        PH_CATCH = 2'h3
    } phase_t;
endpackage

// >>> inc/ram_port_if.sv
// one ram port between the decoder and a byte ram
`timescale 1ns/1ps
interface ram_port_if #(
    parameter int AW = 7,
    parameter int DW = 8
) ();
    logic wrEn; // write strobe
    logic [AW-1:0] addr; // shared read and write address
    logic [DW-1:0] wrData; // byte to store
    logic [DW-1:0] rdData; // registered read byte
    modport owner (output wrEn, output addr, output wrData, input rdData);
    modport store (input wrEn, input addr, input wrData, output rdData);
endinterface

// >>> hdl/byte_ram.sv
// single port byte ram with registered read data
`timescale 1ns/1ps
module byte_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // clock
    input wire logic clk,
    // access port
    ram_port_if.store port
);
    // storage, no reset: contents are undefined until written
    logic [DW-1:0] mem [2**AW];

    // read first: the write lands in the array, read returns the old byte
    always_ff @(posedge clk) begin
        if (port.wrEn) begin
            mem[port.addr] <= port.wrData;
        end
        port.rdData <= mem[port.addr];
    end
endmodule

// >>> hdl/unused_placeholder_none.sv
// intentionally empty file holder for nothing
`timescale 1ns/1ps

// >>> test/lcd_host_model.sv
// host microcontroller model driving the parallel instruction port
`timescale 1ns/1ps
module lcd_host_model (
    // clock
    input wire logic clk,
    // pins toward the device
    output logic selectLineHigh,
    output logic selectLineLow,
    output logic readNotWrite,
    output logic strobe,
    output logic [7:0] dataIn,
    // answer from the device
    input wire logic [7:0] dataOut,
    input wire logic dataOe
);
    // idle pins at time zero, read level as the pull-up leaves it
    initial begin
        selectLineHigh = 1'b0;
        selectLineLow = 1'b0;
        readNotWrite = 1'b1;
        strobe = 1'b0;
        dataIn = 8'h00;
    end

    // one 8-bit transfer; pins settle 3 clk before strobe, held until it falls
    task automatic xfer(input logic hi, input logic lo, input logic rw,
                        input logic [7:0] d, output logic [7:0] rd);
        logic got;
        got = 1'b0;
        rd = 8'h00;
        @(negedge clk);
        selectLineHigh = hi;
        selectLineLow = lo;
        readNotWrite = rw;
        // a released bus must not keep showing the last byte
        dataIn = rw ? ~dataIn : d;
        repeat (3) @(negedge clk);
        strobe = 1'b1;
        // read byte taken at the first edge that sees the enable
        repeat (7) begin
            @(posedge clk);
            if (dataOe === 1'b1 && !got) begin
                rd = dataOut;
                got = 1'b1;
            end
        end
        @(negedge clk);
        strobe = 1'b0;
        // low time covers the device's strobe synchroniser
        repeat (5) @(negedge clk);
    endtask

    task automatic waitReady(output logic [7:0] st);
        st = 8'hFF;
        for (int k = 0; k < 60 && st[7] !== 1'b0; k++) begin
            xfer(1'b1, 1'b0, 1'b1, 8'h00, st);
        end
    endtask
endmodule

// >>> test/lcd_instruction_decoder_tb.sv
// self-checking bench for the lcd instruction decoder
`timescale 1ns/1ps
module lcd_instruction_decoder_tb;
    // clock, reset and side inputs
    logic clk, rst_n, commonScanReverse, entryIncrement, twoLineMode, largeFont;
    // host pins and device answers
    logic selectLineHigh, selectLineLow, readNotWrite, strobe, dataOe, busyIndicator;
    logic iconRowLineSelect;
    logic [7:0] dataIn, dataOut, rd, st;
    logic [4:0] iconCommon, lcdDriveVoltage;
    // bookkeeping
    int nErrors = 0;
    int checksDone = 0;
    int cycles = 0;
    int busyLen = 0;
    int lastBusy = 0;
    // rows: {high, low, read, inc} nibble, byte sent, byte expected
    // valid addresses, address set before reads
    logic [19:0] rows [32] = '{
        20'h9_85_00, 20'hB_00_05, 20'hD_A5_00, 20'hB_00_06, // text set, write
        20'h9_85_00, 20'hF_00_A5, 20'hB_00_06,              // read back, step
        20'h9_45_00, 20'hD_3C_00, 20'h9_85_00, 20'hF_00_A5, // glyph apart
        20'h9_45_00, 20'hF_00_3C,                           // glyph back
        20'h1_63_00, 20'hD_5A_00, 20'h1_63_00, 20'hF_00_5A, // icon ram
        20'h8_90_00, 20'hC_11_00, 20'hA_00_0F,              // step down
        20'h1_20_00, 20'h3_00_00, 20'h1_3F_00, 20'h3_00_1F, // contrast ends
        20'h1_03_00,                                        // line select
        20'h9_C5_00, 20'hD_3E_00, 20'hD_7C_00, 20'h9_C5_00, // two-line writes
        20'hF_00_3E, 20'hF_00_7C, 20'hB_00_47};             // reads in a row
    // {scan reverse, two-line, large font, expected common}
    logic [7:0] comTbl [4] = '{8'h01, 8'h89, 8'hAC, 8'hD1};

    // device under test
    lcd_instruction_decoder u_lcd_instruction_decoder (
        .clk(clk), .rst_n(rst_n),
        .selectLineHigh(selectLineHigh), .selectLineLow(selectLineLow),
        .readNotWrite(readNotWrite), .strobe(strobe), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe), .commonScanReverse(commonScanReverse),
        .entryIncrement(entryIncrement), .twoLineMode(twoLineMode), .largeFont(largeFont),
        .busyIndicator(busyIndicator), .iconRowLineSelect(iconRowLineSelect),
        .iconCommon(iconCommon), .lcdDriveVoltage(lcdDriveVoltage));

    // host on the far side of the port
    lcd_host_model u_lcd_host_model (
        .clk(clk), .selectLineHigh(selectLineHigh), .selectLineLow(selectLineLow),
        .readNotWrite(readNotWrite), .strobe(strobe), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // busy span counter and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (busyIndicator === 1'b1) begin
            busyLen <= busyLen + 1;
        end else if (busyLen != 0) begin
            lastBusy <= busyLen;
            busyLen <= 0;
        end
        if (cycles == 30000) begin
            nErrors++;
            conclude();
        end
    end

    // compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp) begin
            nErrors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic conclude();
        if (nErrors == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {commonScanReverse, twoLineMode, largeFont} = 3'b000;
        entryIncrement = 1'b1;
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 32; i++) begin
            @(negedge clk);
            entryIncrement = rows[i][16];
            // rows from 25 on run in two-line mode
            twoLineMode = (i >= 25);
            u_lcd_host_model.xfer(rows[i][19], rows[i][18], rows[i][17],
                rows[i][15:8], rd);
            if (rows[i][17]) check(rd, rows[i][7:0]);
            u_lcd_host_model.waitReady(st);
            check({7'h00, st[7]}, 8'h00);
        end
        check({3'h0, lcdDriveVoltage}, 8'h1F);
        check({7'h00, iconRowLineSelect}, 8'h01);
        // busy span of the last timed instruction, the final data read
        check({7'h00, lastBusy inside {[334:370]}}, 8'h01);
        // icon common per scan order and duty
        for (int j = 0; j < 4; j++) begin
            @(negedge clk);
            {commonScanReverse, twoLineMode, largeFont} = comTbl[j][7:5];
            repeat (6) @(negedge clk);
            check({3'h0, iconCommon}, {3'h0, comTbl[j][4:0]});
        end
        {commonScanReverse, twoLineMode, largeFont} = 3'b000;
        u_lcd_host_model.xfer(1'b1, 1'b0, 1'b0, 8'h8A, rd);
        u_lcd_host_model.xfer(1'b1, 1'b0, 1'b1, 8'h00, st);
        check({7'h00, st[7]}, 8'h01);
        u_lcd_host_model.xfer(1'b1, 1'b1, 1'b0, 8'h77, rd);
        u_lcd_host_model.xfer(1'b0, 1'b0, 1'b0, 8'h2A, rd);
        u_lcd_host_model.waitReady(st);
        check(st, 8'h0A);
        check({3'h0, lcdDriveVoltage}, 8'h1F);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        check({dataOe, busyIndicator, iconRowLineSelect, iconCommon}, 8'h09);
        check({3'h0, lcdDriveVoltage}, 8'h00);
        rst_n = 1'b1;
        u_lcd_host_model.xfer(1'b1, 1'b0, 1'b1, 8'h00, st);
        check(st, 8'h00);
        // line select low under reverse scan: first common
        commonScanReverse = 1'b1;
        repeat (6) @(negedge clk);
        check({3'h0, iconCommon}, 8'h01);
        conclude();
    end
endmodule
